//--- verilog/rshc_pkg.sv
package rshc_pkg;
  // ****************************************
  // character codes
  // ****************************************
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam int DATA_W = 8;
  // ****************************************
  // serial timing
  // ****************************************
  localparam int CLK_HZ = 100000000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
  localparam int FRAME_BITS = 10;
  localparam int MSG_DEPTH = 64;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic RTS_ACTIVE_RST = 1'b0;
  localparam logic TXD_IDLE = 1'b1;
endpackage : rshc_pkg

//--- verilog/rshc_char_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rshc_char_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : rshc_char_if
`default_nettype wire

//--- verilog/rshc_rx.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_rx #(
  parameter int BIT_CYCLES = rshc_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // serial line
  input wire logic i_rxd,
  // received characters
  rshc_char_if.src o_char
);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rshc_rx_state_t;
  rshc_rx_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [2:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic vld, next_vld;
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  // edge already seen one cycle late, so count one less to land mid-bit
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);
  assign o_char.valid = vld;
  assign o_char.data = sh;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_vld = 1'b0;
    unique case (state)
      RX_IDLE: begin
        // start bit opens a character
        if (!i_rxd) begin
          next_state = RX_START;
          next_cnt = HALF;
        end
      end
      RX_START: begin
        if (cnt == 16'h0000) begin
          next_state = i_rxd ? RX_IDLE : RX_DATA;
          next_cnt = FULL;
          next_bitn = 3'h0;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      RX_DATA: begin
        if (cnt == 16'h0000) begin
          next_sh = {i_rxd, sh[7:1]};
          next_cnt = FULL;
          next_bitn = bitn + 3'h1;
          if (bitn == 3'h7) begin
            next_state = RX_STOP;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      RX_STOP: begin
        if (cnt == 16'h0000) begin
          next_state = RX_IDLE;
          next_vld = i_rxd;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= RX_IDLE;
      cnt <= 16'h0000;
      bitn <= 3'h0;
      sh <= 8'h00;
      vld <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      vld <= next_vld;
    end
  end
endmodule : rshc_rx
`default_nettype wire

//--- verilog/rshc_tx.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_tx #(
  parameter int BIT_CYCLES = rshc_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // characters to send
  rshc_char_if.dst i_char,
  // serial line
  output logic o_txd
);
  typedef enum {TX_IDLE, TX_SHIFT} rshc_tx_state_t;
  rshc_tx_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [9:0] sh, next_sh;
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  assign i_char.ready = (state == TX_IDLE);
  assign o_txd = sh[0];
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    unique case (state)
      TX_IDLE: begin
        if (i_char.valid) begin
          next_state = TX_SHIFT;
          next_sh = {1'b1, i_char.data, 1'b0};
          next_cnt = FULL;
          next_bitn = 4'h0;
        end
      end
      TX_SHIFT: begin
        // a started character always runs to its stop bit
        if (cnt == 16'h0000) begin
          next_cnt = FULL;
          next_sh = {1'b1, sh[9:1]};
          next_bitn = bitn + 4'h1;
          if (bitn == 4'h9) begin
            next_state = TX_IDLE;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= TX_IDLE;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      sh <= 10'h3ff;
    end else if (i_ce) begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
    end
  end
endmodule : rshc_tx
`default_nettype wire

//--- verilog/rshc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - terminal-ready output is true from power-up and stays true.
// - a start bit on receive data brings in one character to the buffer.
// - characters arriving while carrier-detect is false are discarded.
// - accepted characters collect into the message until a line feed.
// - line feed raises the send holdoff until the reply is fully sent.
// - each reply character waits for clear-to-send and data-set-ready.
// - once started, a character ignores those inputs and is never aborted.
// - after the reply line feed the holdoff drops and reception resumes.
// - holdoff output resets low (asserted if switch 2 is open) and is negated from the second enabled edge until the first terminator.
// - switch 2 open at power-up inverts the holdoff output polarity.
// - factory setting forces the three handshake inputs true.
module rshc_top #(
  parameter int BIT_CYCLES = rshc_pkg::BIT_CYCLES,
  parameter int MSG_DEPTH = rshc_pkg::MSG_DEPTH
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // serial data
  input wire logic i_rxd,
  output logic o_txd,
  // handshake inputs from host
  input wire logic i_cts,
  input wire logic i_dsr,
  input wire logic i_dcd,
  // handshake outputs to host
  output logic o_dtr,
  output logic o_rts,
  // configuration straps
  input wire logic i_sw_force_true,
  input wire logic i_sw2_open,
  // message to decoder
  output logic o_msg_done,
  output logic [$clog2(MSG_DEPTH+1)-1:0] o_msg_len,
  output logic [7:0] o_msg_char,
  input wire logic [$clog2(MSG_DEPTH)-1:0] i_msg_idx,
  // reply from decoder
  input wire logic i_reply_valid,
  input wire logic [7:0] i_reply_data,
  output logic o_reply_ready
);
  localparam int LW = $clog2(MSG_DEPTH + 1);
  localparam int IW = $clog2(MSG_DEPTH);
  // ****************************************
  // character engines
  // ****************************************
  rshc_char_if rx_if ();
  rshc_char_if tx_if ();
  logic txd_raw;
  rshc_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_rxd(i_rxd),
    .o_char(rx_if)
  );
  rshc_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_char(tx_if),
    .o_txd(txd_raw)
  );
  // ****************************************
  // strap capture
  // ****************************************
  // straps caught on the first enabled edge after release, never again
  logic strap_done, next_strap_done;
  logic rts_inv, next_rts_inv;
  logic force_true, next_force_true;
  always_comb begin
    next_strap_done = 1'b1;
    next_rts_inv = rts_inv;
    next_force_true = force_true;
    if (!strap_done) begin
      next_rts_inv = i_sw2_open;
      next_force_true = i_sw_force_true;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_done <= 1'b0;
      rts_inv <= 1'b0;
      force_true <= 1'b1;
    end else if (i_ce) begin
      strap_done <= next_strap_done;
      rts_inv <= next_rts_inv;
      force_true <= next_force_true;
    end
  end
  logic dcd_eff, cts_eff, dsr_eff;
  assign dcd_eff = force_true | i_dcd;
  assign cts_eff = force_true | i_cts;
  assign dsr_eff = force_true | i_dsr;
  logic pace_ok;
  assign pace_ok = cts_eff & dsr_eff;
  // ****************************************
  // message sequencer
  // ****************************************
  typedef enum {SQ_RECV, SQ_REPLY, SQ_DRAIN} rshc_seq_state_t;
  rshc_seq_state_t state, next_state;
  logic [7:0] buf_mem [MSG_DEPTH];
  logic [7:0] next_buf_wr;
  logic buf_we;
  logic [LW-1:0] len, next_len;
  logic holdoff, next_holdoff;
  logic done, next_done;
  logic tx_vld, next_tx_vld;
  logic [7:0] tx_dat, next_tx_dat;
  logic last_lf, next_last_lf;
  logic rdy, next_rdy;
  logic [7:0] mchar, next_mchar;
  function automatic logic is_lf(input logic [7:0] c);
    return c == rshc_pkg::CHAR_LF;
  endfunction : is_lf
  // byte held back until the host can take it, so it cannot slip out early
  assign tx_if.valid = tx_vld & pace_ok;
  assign tx_if.data = tx_dat;
  assign rx_if.ready = 1'b1;
  always_comb begin
    next_state = state;
    next_len = len;
    next_holdoff = holdoff;
    next_done = 1'b0;
    next_tx_vld = tx_vld;
    next_tx_dat = tx_dat;
    next_last_lf = last_lf;
    next_rdy = 1'b0;
    next_mchar = buf_mem[i_msg_idx];
    buf_we = 1'b0;
    next_buf_wr = rx_if.data;
    unique case (state)
      SQ_RECV: begin
        // carrier-detect judged when the character completes
        if (rx_if.valid && dcd_eff) begin
          if (len < LW'(MSG_DEPTH)) begin
            buf_we = 1'b1;
            next_len = len + LW'(1);
          end
          if (is_lf(rx_if.data)) begin
            next_holdoff = 1'b1;
            next_done = 1'b1;
            next_state = SQ_REPLY;
          end
        end
      end
      SQ_REPLY: begin
        next_rdy = !tx_vld && !(i_reply_valid && o_reply_ready);
        if (i_reply_valid && o_reply_ready) begin
          next_tx_vld = 1'b1;
          next_tx_dat = i_reply_data;
          next_last_lf = is_lf(i_reply_data);
        end
        // pacing checked only before a character starts
        if (tx_vld && tx_if.ready && cts_eff && dsr_eff) begin
          next_tx_vld = 1'b0;
          if (last_lf) begin
            next_state = SQ_DRAIN;
          end
        end
      end
      SQ_DRAIN: begin
        // holdoff stays until the terminator's stop bit is out
        if (tx_if.ready) begin
          next_holdoff = 1'b0;
          next_len = '0;
          next_state = SQ_RECV;
        end
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SQ_RECV;
      len <= '0;
      holdoff <= 1'b0;
      done <= 1'b0;
      tx_vld <= 1'b0;
      tx_dat <= 8'h00;
      last_lf <= 1'b0;
      rdy <= 1'b0;
      mchar <= 8'h00;
    end else if (i_ce) begin
      state <= next_state;
      len <= next_len;
      holdoff <= next_holdoff;
      done <= next_done;
      tx_vld <= next_tx_vld;
      tx_dat <= next_tx_dat;
      last_lf <= next_last_lf;
      rdy <= next_rdy;
      mchar <= next_mchar;
    end
  end
  // buffer has no reset: contents are only valid below len
  always_ff @(posedge i_clk_sys) begin
    if (i_ce && buf_we) begin
      buf_mem[len[IW-1:0]] <= next_buf_wr;
    end
  end
  // ****************************************
  // output registers
  // ****************************************
  logic rts_q, next_rts_q;
  logic dtr_q, next_dtr_q;
  logic txd_q;
  always_comb begin
    next_rts_q = holdoff ^ rts_inv;
    next_dtr_q = 1'b1;
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rts_q <= rshc_pkg::RTS_ACTIVE_RST;
      dtr_q <= 1'b1;
      txd_q <= rshc_pkg::TXD_IDLE;
    end else if (i_ce) begin
      rts_q <= next_rts_q;
      dtr_q <= next_dtr_q;
      txd_q <= txd_raw;
    end
  end
  assign o_rts = rts_q;
  assign o_dtr = dtr_q;
  assign o_txd = txd_q;
  assign o_msg_done = done;
  assign o_msg_len = len;
  assign o_msg_char = mchar;
  assign o_reply_ready = rdy;
  // ****************************************
  // checks
  // ****************************************
  chk_dtr_always: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_dtr)
    else $error("terminal ready dropped");
  chk_rx_discard: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && state == SQ_RECV && rx_if.valid && !dcd_eff) |=> $stable(len))
    else $error("character kept without carrier");
  chk_lf_holdoff: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && state == SQ_RECV && rx_if.valid && dcd_eff && is_lf(rx_if.data))
    |=> holdoff && state == SQ_REPLY)
    else $error("terminator did not raise holdoff");
  chk_pace_wait: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (tx_vld && !(cts_eff && dsr_eff)) |=> tx_vld)
    else $error("character started without pacing");
  chk_drain_end: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && state == SQ_DRAIN && tx_if.ready) |=> !holdoff ##1 (rts_q == rts_inv))
    else $error("holdoff not released after reply");
  chk_rts_polar: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && strap_done) |=> rts_q == ($past(holdoff) ^ $past(rts_inv)))
    else $error("request to send polarity wrong");
  chk_strap_hold: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(strap_done) |-> $stable(rts_inv))
    else $error("polarity strap changed after start");
  chk_hold_reply: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state != SQ_RECV) |-> holdoff)
    else $error("holdoff dropped during reply");
  chk_recv_quiet: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == SQ_RECV) |-> !holdoff)
    else $error("holdoff raised while receiving");
  chk_len_cap: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    len <= LW'(MSG_DEPTH))
    else $error("message length beyond buffer");
  chk_pace_start: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $fell(tx_if.ready) |-> $past(pace_ok))
    else $error("character started without pacing inputs");
  // ****************************************
  // check helpers
  // ****************************************
  // busy span of the transmitter; an aborted character comes up short
  localparam logic [19:0] CHAR_CYCLES = 20'(rshc_pkg::FRAME_BITS * BIT_CYCLES);
  logic [19:0] busy_cnt, next_busy_cnt;
  always_comb begin
    next_busy_cnt = 20'h00000;
    if (!tx_if.ready) begin
      next_busy_cnt = busy_cnt + 20'h00001;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 20'h00000;
    end else if (i_ce) begin
      busy_cnt <= next_busy_cnt;
    end
  end
  chk_char_whole: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(tx_if.ready) |-> busy_cnt == CHAR_CYCLES)
    else $error("character cut short");
endmodule : rshc_top
`default_nettype wire

//--- bench/rshc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_host #(
  parameter int BC = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // serial lines
  input wire logic i_txd,
  output logic o_rxd,
  // holdoff from device
  input wire logic i_rts,
  input wire logic i_inv
);
  byte unsigned rx_q[$];
  initial o_rxd = 1'b1;
  // ****
  // toward device, lsb first
  // ****
  task automatic send_char(input logic [7:0] c);
    int n;
    n = 0;
    while ((i_rts ^ i_inv) === 1'b1 && n < 5000) begin
      @(negedge i_clk_sys);
      n++;
    end
    o_rxd = 1'b0;
    repeat (BC) @(negedge i_clk_sys);
    for (int i = 0; i < 8; i++) begin
      o_rxd = c[i];
      repeat (BC) @(negedge i_clk_sys);
    end
    o_rxd = 1'b1;
    repeat (BC) @(negedge i_clk_sys);
  endtask : send_char
  // ****
  // from device, sampled mid-bit
  // ****
  always begin
    logic [7:0] b;
    wait (i_rst_n === 1'b1);
    @(negedge i_txd);
    repeat (BC + BC / 2) @(posedge i_clk_sys);
    for (int i = 0; i < 8; i++) begin
      b[i] = i_txd;
      repeat (BC) @(posedge i_clk_sys);
    end
    rx_q.push_back(b);
  end
endmodule : rshc_host
`default_nettype wire

//--- bench/rshc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_top_tb;
  localparam int BC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cts = 1'b1;
  logic dsr = 1'b1;
  logic dcd = 1'b1;
  logic ce = 1'b1;
  logic sw_f = 1'b0;
  logic sw2 = 1'b0;
  logic inv = 1'b0;
  logic rvalid = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic [5:0] idx = 6'h00;
  logic rxd, txd, dtr, rts, done, rready;
  logic [6:0] len;
  logic [7:0] mchar;
  int num_errors = 0;
  int samples_checked = 0;
  int done_cnt = 0;
  integer seed = 32'hc4d431a2;
  int exp_msg[$];
  int exp_rep[$];
  always #5 clk = ~clk;
  always @(posedge clk) if (done === 1'b1) done_cnt++;
  rshc_top #(.BIT_CYCLES(BC), .MSG_DEPTH(64)) uut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_rxd(rxd), .o_txd(txd), .i_cts(cts), .i_dsr(dsr), .i_dcd(dcd),
    .o_dtr(dtr), .o_rts(rts), .i_sw_force_true(sw_f), .i_sw2_open(sw2),
    .o_msg_done(done), .o_msg_len(len), .o_msg_char(mchar), .i_msg_idx(idx),
    .i_reply_valid(rvalid), .i_reply_data(rdata), .o_reply_ready(rready));
  rshc_host #(.BC(BC)) host (.i_clk_sys(clk), .i_rst_n(rst_n), .i_txd(txd),
    .o_rxd(rxd), .i_rts(rts), .i_inv(inv));
  // ****
  // helpers
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic do_reset(input logic f, input logic s2);
    rst_n = 1'b0;
    sw_f = f;
    sw2 = s2;
    inv = s2;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset
  task automatic send_msg(input int n, input int bad);
    logic [7:0] c;
    int k;
    exp_msg = {};
    k = done_cnt;
    for (int i = 0; i <= n; i++) begin
      c = (i == n) ? rshc_pkg::CHAR_LF : 8'h20 + 8'($random(seed) & 8'h3f);
      dcd = (i != bad);
      if (dcd || sw_f) exp_msg.push_back(c);
      host.send_char(c);
      // idle gap: carrier must stand past the stop-bit judgement
      repeat (2) @(negedge clk);
    end
    dcd = 1'b1;
    repeat (8) @(negedge clk);
    check(done_cnt, k + 1);
    check(len, exp_msg.size());
    foreach (exp_msg[j]) begin
      idx = 6'(j);
      @(negedge clk);
      check(mchar, exp_msg[j]);
    end
    check(rts, 1'b1 ^ inv);
  endtask : send_msg
  task automatic send_rep(input int n);
    int k;
    for (int i = 0; i <= n; i++) begin
      rdata = (i == n) ? rshc_pkg::CHAR_LF : 8'h20 + 8'($random(seed) & 8'h3f);
      rvalid = 1'b1;
      exp_rep.push_back(rdata);
      k = 0;
      while (rready !== 1'b1 && k < 3000) begin
        @(negedge clk);
        k++;
      end
      @(negedge clk);
      check(rready, 1'b0);
    end
    rvalid = 1'b0;
  endtask : send_rep
  task automatic cmp_rx();
    int k;
    k = 0;
    while (host.rx_q.size() < exp_rep.size() && k < 5000) begin
      @(negedge clk);
      k++;
    end
    check(host.rx_q.size(), exp_rep.size());
    foreach (exp_rep[j]) check(host.rx_q[j], exp_rep[j]);
    host.rx_q = {};
    exp_rep = {};
    repeat (3 * BC) @(negedge clk);
    check(rts, inv);
    check(dtr, 1'b1);
  endtask : cmp_rx
  // ****
  // tests
  // ****
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    do_reset(1'b0, 1'b0);
    check(dtr, 1'b1);
    check(rts, 1'b0);
    check(txd, 1'b1);
    send_msg(5, 2);
    cts = 1'b0;
    fork
      send_rep(3);
      begin
        repeat (40) begin
          @(negedge clk);
          check(txd, 1'b1);
        end
        cts = 1'b1;
        @(negedge txd);
        repeat (BC) @(negedge clk);
        dsr = 1'b0;
        repeat (10 * BC) @(negedge clk);
        repeat (2 * BC) begin
          @(negedge clk);
          check(txd, 1'b1);
        end
        dsr = 1'b1;
      end
    join
    cmp_rx();
    $display("test 1 done");
    send_msg(3, -1);
    ce = 1'b0;
    rdata = 8'h41;
    rvalid = 1'b1;
    repeat (10) @(negedge clk);
    check(rready, 1'b1);
    check(txd, 1'b1);
    ce = 1'b1;
    send_rep(0);
    cmp_rx();
    $display("test 2 done");
    do_reset(1'b0, 1'b1);
    check(rts, 1'b1);
    sw2 = 1'b0;
    send_msg(2, -1);
    send_rep(1);
    cmp_rx();
    $display("test 3 done");
    do_reset(1'b1, 1'b0);
    cts = 1'b0;
    dsr = 1'b0;
    send_msg(3, 0);
    send_rep(2);
    cmp_rx();
    cts = 1'b1;
    dsr = 1'b1;
    $display("test 4 done");
    close_out();
  end
endmodule : rshc_top_tb
`default_nettype wire
